// >>> src/pport_consts.svh
// timing counts and constants for the parallel port handshake block
// assumes a 40 MHz system clock (25 ns period)
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH

`define CLK_PERIOD_NS      25
// wait input must be quiet this long before it counts as settled
`define WAIT_SETTLE_NS     50
`define WAIT_SETTLE_CYC    ((`WAIT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// data setup before strobe falls in fifo mode
`define FIFO_SETUP_NS      600
`define FIFO_SETUP_CYC     ((`FIFO_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// strobe low pulse width in fifo mode
`define FIFO_PULSE_NS      600
`define FIFO_PULSE_CYC     ((`FIFO_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// busy/ack quiet time before a level is believed in ecp mode
`define ECP_SETTLE_NS      130
`define ECP_SETTLE_CYC     ((`ECP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH         8
`define DATA_W             8

`endif

// >>> src/pport_pkg.sv
// types shared by the parallel port handshake block
// assumes pport_consts.svh for numbers
package pport_pkg;
  typedef enum logic [1:0] {
    MODE_FIFO,
    MODE_ECP,
    MODE_EPP
  } port_mode_t;

  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_WAIT_BUSY_HI,
    ST_WAIT_BUSY_LO,
    ST_REV_IDLE,
    ST_REV_ACK_HI,
    ST_REV_WAIT_ACK_HI,
    ST_EPP_CMD,
    ST_EPP_END
  } hs_state_t;
endpackage : pport_pkg

// >>> src/byte_stream_if.sv
// valid/ready byte stream between the fifo and the handshake engine
// assumes a single clock domain
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : byte_stream_if

// >>> src/byte_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // streams
  byte_stream_if.dst in_s,
  byte_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_s.ready  = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// >>> src/pport_handshake.sv
// host-side handshake engine of a multi-mode parallel port
// assumes i_clk at 40 MHz, cable inputs asynchronous, user side on i_clk
//
// Behaviour
// - fifo mode ignores acknowledge; next byte paced by busy and the setup and pulse timers
// - forward idle: strobe held high, peripheral keeps busy low
// - forward: busy low, data then strobe low, busy high, strobe high, busy low
// - reverse idle: peripheral ack high, host autofeed low
// - reverse: autofeed low, ack low, accept and autofeed high, ack high, autofeed low
// - push-pull drive in ecp, open-collector in compatible, switched glitch free
// - epp wait input settled only after 50 ns without transition
// - epp write-direction output stays high outside write cycles
// - reverse transfer stalls by keeping autofeed low when no room
`timescale 1ns/10ps
`include "pport_consts.svh"
module pport_handshake
  import pport_pkg::*;
#(
  parameter int W     = `DATA_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // mode and direction control
  input  wire port_mode_t   i_mode,
  input  wire logic         i_reverse,
  input  wire logic         i_epp_write,
  // transmit stream from dma path
  input  wire logic         i_tx_valid,
  input  wire logic [W-1:0] i_tx_data,
  output logic              o_tx_ready,
  // receive stream to dma path
  output logic              o_rx_valid,
  output logic [W-1:0]      o_rx_data,
  input  wire logic         i_rx_ready,
  input  wire logic         i_rx_stop,
  // status
  output logic              o_reverse_req,
  output logic              o_epp_done,
  // cable data lines
  input  wire logic [W-1:0] i_port_data_lines,
  output logic [W-1:0]      o_port_data_lines,
  output logic              o_port_data_oe,
  // cable control outputs (strobe and autofeed open-collector in compatible mode, write always driven)
  output logic              o_strobe_n,
  output logic              o_strobe_oe,
  output logic              o_autofd_n,
  output logic              o_autofd_oe,
  output logic              o_write_n,
  // cable status inputs
  input  wire logic         i_busy,
  input  wire logic         i_ack_n,
  input  wire logic         i_fault_n,
  input  wire logic         i_wait_n
);
  byte_stream_if #(.W(W)) tx_in ();
  byte_stream_if #(.W(W)) tx_out ();

  assign tx_in.valid = i_tx_valid;
  assign tx_in.data  = i_tx_data;
  assign o_tx_ready  = tx_in.ready;

  byte_fifo #(.W(W), .DEPTH(DEPTH)) u_tx_fifo (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .in_s  (tx_in),
    .out_s (tx_out)
  );

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  logic [3:0]   sync1;
  logic [3:0]   sync2;
  logic [W-1:0] data_s1;
  logic [W-1:0] data_s2;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1   <= 4'hF;
      sync2   <= 4'hF;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      sync1   <= {i_busy, i_ack_n, i_fault_n, i_wait_n};
      sync2   <= sync1;
      data_s1 <= i_port_data_lines;
      data_s2 <= data_s1;
    end
  end

  // -------------------------------------------------------------------------
  // settle filters
  // -------------------------------------------------------------------------
  // busy, ack and fault share the ecp settle time; wait uses its own
  localparam logic [7:0] SETTLE_CYC [4] = '{8'(`ECP_SETTLE_CYC), 8'(`ECP_SETTLE_CYC),
                                            8'(`ECP_SETTLE_CYC), 8'(`WAIT_SETTLE_CYC)};
  logic [3:0] filt;
  logic [3:0] prev;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_filt
      logic [7:0] quiet;
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          quiet   <= '0;
          prev[g] <= 1'b1;
          filt[3-g] <= 1'b1;
        end else begin
          prev[g] <= sync2[3-g];
          if (sync2[3-g] != prev[g]) begin
            quiet <= '0;
          end else if (quiet < SETTLE_CYC[g]) begin
            quiet <= quiet + 8'h01;
          end else begin
            filt[3-g] <= sync2[3-g];
          end
        end
      end
    end
  endgenerate

  logic busy_f;
  logic ack_n_f;
  logic fault_n_f;
  logic wait_n_f;
  assign busy_f    = filt[3];
  assign ack_n_f   = filt[2];
  assign fault_n_f = filt[1];
  assign wait_n_f  = filt[0];

  // -------------------------------------------------------------------------
  // handshake state machine
  // -------------------------------------------------------------------------
  hs_state_t  state;
  logic [7:0] timer;
  logic       rx_pending;

  assign tx_out.ready = (state == ST_IDLE) && !i_reverse && (i_mode != MODE_EPP || i_epp_write);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state             <= ST_IDLE;
      timer             <= '0;
      o_port_data_lines <= '0;
      o_strobe_n        <= 1'b1;
      o_autofd_n        <= 1'b1;
      o_write_n         <= 1'b1;
      o_epp_done        <= 1'b0;
      o_rx_data         <= '0;
    end else begin
      o_epp_done <= 1'b0;
      timer      <= (timer == 8'h00) ? 8'h00 : timer - 8'h01;
      case (state)
        ST_IDLE: begin
          o_strobe_n <= 1'b1;
          o_write_n  <= 1'b1;
          o_autofd_n <= 1'b1;
          if (i_reverse && i_mode == MODE_ECP) begin
            o_autofd_n <= 1'b0;
            state      <= ST_REV_IDLE;
          end else if (tx_out.valid && tx_out.ready) begin
            o_port_data_lines <= tx_out.data;
            timer             <= 8'(`FIFO_SETUP_CYC);
            if (i_mode == MODE_EPP) begin
              o_write_n <= 1'b0;
            end
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // fifo mode waits for setup time and busy low; ecp waits for busy low only
          if (i_mode == MODE_EPP) begin
            if (!wait_n_f) begin
              o_strobe_n <= 1'b0;
              state      <= ST_EPP_CMD;
            end
          end else if (!busy_f && (i_mode == MODE_ECP || timer == 8'h00)) begin
            o_strobe_n <= 1'b0;
            timer      <= 8'(`FIFO_PULSE_CYC);
            state      <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (i_mode == MODE_FIFO) begin
            if (timer == 8'h00) begin
              o_strobe_n <= 1'b1;
              state      <= ST_WAIT_BUSY_LO;
            end
          end else if (busy_f) begin
            o_strobe_n <= 1'b1;
            state      <= ST_WAIT_BUSY_LO;
          end
        end
        ST_WAIT_BUSY_HI: begin
          state <= ST_WAIT_BUSY_LO;
        end
        ST_WAIT_BUSY_LO: begin
          // peripheral takes the byte and drops busy; data held until then
          if (!busy_f) begin
            state <= ST_IDLE;
          end
        end
        ST_REV_IDLE: begin
          o_autofd_n <= 1'b0;
          if (!i_reverse) begin
            state <= ST_IDLE;
          end else if (!ack_n_f && !rx_pending && !i_rx_stop) begin
            o_rx_data  <= data_s2;
            o_autofd_n <= 1'b1;
            state      <= ST_REV_WAIT_ACK_HI;
          end
        end
        ST_REV_WAIT_ACK_HI: begin
          if (ack_n_f) begin
            o_autofd_n <= 1'b0;
            state      <= ST_REV_IDLE;
          end
        end
        ST_EPP_CMD: begin
          if (wait_n_f) begin
            o_strobe_n <= 1'b1;
            o_epp_done <= 1'b1;
            state      <= ST_EPP_END;
          end
        end
        ST_EPP_END: begin
          o_write_n <= 1'b1;
          state     <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // received byte held until the dma path takes it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_pending <= 1'b0;
    end else if (state == ST_REV_IDLE && !ack_n_f && !rx_pending && !i_rx_stop && i_reverse) begin
      rx_pending <= 1'b1;
    end else if (i_rx_ready) begin
      rx_pending <= 1'b0;
    end
  end
  assign o_rx_valid = rx_pending;

  // reversal request may come at any moment in ecp mode forward phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reverse_req <= 1'b0;
    end else begin
      o_reverse_req <= (i_mode == MODE_ECP) && !i_reverse && !fault_n_f;
    end
  end

  // -------------------------------------------------------------------------
  // output drivers
  // -------------------------------------------------------------------------
  // enables are registered so a mode change cannot glitch a pin
  logic push_pull;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      push_pull      <= 1'b0;
      o_port_data_oe <= 1'b1;
    end else begin
      push_pull      <= (i_mode != MODE_FIFO);
      o_port_data_oe <= !i_reverse && !(i_mode == MODE_EPP && !i_epp_write);
    end
  end
  assign o_strobe_oe = push_pull || !o_strobe_n;
  assign o_autofd_oe = push_pull || !o_autofd_n;
endmodule : pport_handshake

// >>> sim/pport_props.sv
// assertions on the port handshake engine
// assumes only the top-level ports are visible
`timescale 1ns/10ps
module pport_props
  import pport_pkg::*;
(
  // control
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire port_mode_t i_mode,
  input wire logic       i_reverse,
  input wire logic       i_rx_stop,
  input wire logic       i_busy,
  input wire logic       i_ack_n,
  input wire logic       i_wait_n,
  // outputs
  input wire logic       o_rx_valid,
  input wire logic       o_strobe_n,
  input wire logic       o_strobe_oe,
  input wire logic       o_autofd_n,
  input wire logic       o_write_n,
  input wire logic       o_epp_done,
  input wire logic [7:0] o_port_data_lines
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  strobe_fall_a: assert property ($fell(o_strobe_n) && i_mode != MODE_EPP |-> !$past(i_busy, 4))
    else $error("strobe fell on busy");
  strobe_rise_a: assert property ($rose(o_strobe_n) && i_mode == MODE_ECP |-> $past(i_busy, 4))
    else $error("strobe rose early");
  data_hold_a: assert property (!o_strobe_n && !$past(o_strobe_n) |-> $stable(o_port_data_lines))
    else $error("data moved");
  open_drain_a: assert property (i_mode == MODE_FIFO && $stable(i_mode) |-> o_strobe_oe == !o_strobe_n)
    else $error("strobe drive kind");
  rev_ack_a: assert property ($rose(o_autofd_n) && i_reverse && $past(i_reverse) |-> !$past(i_ack_n, 4))
    else $error("autofeed rose early");
  rev_stall_a: assert property ($rose(o_autofd_n) && i_reverse |->
    !$past(i_rx_stop) && !$past(o_rx_valid))
    else $error("no stall");
  wait_settle_a: assert property ($fell(o_strobe_n) && i_mode == MODE_EPP |-> !$past(i_wait_n, 3))
    else $error("wait not settled");
  // back-to-back writes may drop write again one cycle after the release
  write_idle_a: assert property (o_epp_done |=> o_write_n)
    else $error("write left low");
  write_strobe_a: assert property (i_mode == MODE_EPP && !o_strobe_n |-> !o_write_n)
    else $error("strobe outside write");
  fifo_strobe_c: cover property ($fell(o_strobe_n) && i_mode == MODE_FIFO);
  rev_byte_c: cover property ($rose(o_rx_valid));
  epp_done_c: cover property (o_epp_done);
endmodule : pport_props

bind pport_handshake pport_props pport_props_inst (.i_clk, .i_rst, .i_mode, .i_reverse, .i_rx_stop, .i_busy,
  .i_ack_n, .i_wait_n, .o_rx_valid, .o_strobe_n, .o_strobe_oe, .o_autofd_n, .o_write_n, .o_epp_done,
  .o_port_data_lines);

// >>> sim/printer_model.sv
// behavioural printer on the cable side
// assumes resolved cable levels from the bench
`timescale 1ns/10ps
module printer_model
  import pport_pkg::*;
(
  // bench side
  input  wire logic       i_clk,
  input  wire port_mode_t i_mode,
  input  wire logic       i_stall,
  input  wire logic       i_req,
  input  wire logic [3:0] i_dly,
  // cable
  input  wire logic       i_strobe_n,
  input  wire logic       i_autofd_n,
  input  wire logic       i_write_n,
  input  wire logic [7:0] i_pd,
  output logic            o_busy,
  output logic            o_ack_n,
  output logic            o_fault_n,
  output logic            o_wait_n,
  output logic [7:0]      o_pd
);
  logic [7:0] got[$];
  logic [7:0] snd[$];
  assign o_fault_n = !i_req;
  initial begin
    {o_busy, o_ack_n, o_wait_n, o_pd} = 11'h300;
    forever begin
      @(posedge i_clk);
      if (i_mode == MODE_EPP && !i_write_n) begin
        repeat (i_dly + 1) @(posedge i_clk);
        o_wait_n <= 1'b0;
        wait (!i_strobe_n);
        got.push_back(i_pd);
        repeat (i_dly + 1) @(posedge i_clk);
        o_wait_n <= 1'b1;
        wait (i_write_n);
      end else if (i_mode != MODE_EPP && !i_strobe_n) begin
        repeat (i_dly + 1) @(posedge i_clk);
        o_busy <= 1'b1;
        wait (i_strobe_n);
        got.push_back(i_pd);
        wait (!i_stall);
        @(posedge i_clk);
        o_busy <= 1'b0;
      end else if (i_mode == MODE_ECP && !i_autofd_n && snd.size() > 0) begin
        o_pd <= snd[0];
        repeat (i_dly + 1) @(posedge i_clk);
        o_ack_n <= 1'b0;
        wait (i_autofd_n);
        @(posedge i_clk);
        o_ack_n <= 1'b1;
        o_pd <= ~snd.pop_front();
        wait (!i_autofd_n);
      end else begin
        o_busy <= i_stall;
        o_ack_n <= (i_mode == MODE_FIFO) ? !o_ack_n : 1'b1;
      end
    end
  end
endmodule : printer_model

// >>> sim/ecp_epp_parallel_handshake_tb.sv
// self-checking bench for the port handshake engine
// assumes engine, fifo, checker and printer model compiled first
`timescale 1ns/10ps
module ecp_epp_parallel_handshake_tb;
  import pport_pkg::*;
  logic i_clk, i_rst, i_reverse, i_epp_write, i_tx_valid, i_rx_ready, i_rx_stop, stall, req;
  logic o_tx_ready, o_rx_valid, o_reverse_req, o_epp_done, o_port_data_oe, o_strobe_n, o_strobe_oe;
  logic o_autofd_n, o_autofd_oe, o_write_n, i_busy, i_ack_n, i_fault_n, i_wait_n;
  logic [7:0] i_tx_data, o_rx_data, o_port_data_lines, pm_pd, sent[$];
  logic [3:0] dly;
  port_mode_t i_mode;
  int seed, n_mismatch, checks, cyc, n_done;
  wire stb = o_strobe_oe ? o_strobe_n : 1'b1;
  wire afd = o_autofd_oe ? o_autofd_n : 1'b1;
  wire [7:0] i_port_data_lines = o_port_data_oe ? o_port_data_lines : pm_pd;
  pport_handshake pport_handshake_inst (.i_clk, .i_rst, .i_mode, .i_reverse, .i_epp_write, .i_tx_valid,
    .i_tx_data, .o_tx_ready, .o_rx_valid, .o_rx_data, .i_rx_ready, .i_rx_stop, .o_reverse_req, .o_epp_done,
    .i_port_data_lines, .o_port_data_lines, .o_port_data_oe, .o_strobe_n, .o_strobe_oe, .o_autofd_n,
    .o_autofd_oe, .o_write_n, .i_busy, .i_ack_n, .i_fault_n, .i_wait_n);
  printer_model printer_model_inst (.i_clk, .i_mode, .i_stall(stall), .i_req(req), .i_dly(dly),
    .i_strobe_n(stb), .i_autofd_n(afd), .i_write_n(o_write_n), .i_pd(i_port_data_lines), .o_busy(i_busy),
    .o_ack_n(i_ack_n), .o_fault_n(i_fault_n), .o_wait_n(i_wait_n), .o_pd(pm_pd));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (o_epp_done === 1'b1) n_done++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // a stalled fifo holds its depth plus the byte in the engine
  function automatic logic fill_ok(input int n);
    return n == 9;
  endfunction : fill_ok
  task ck(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : ck
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task fwd(input port_mode_t m, input int n, input logic st);
    int t;
    @(negedge i_clk);
    i_mode = m;
    stall = st;
    dly = 4'($random(seed));
    n_done = 0;
    sent.delete();
    printer_model_inst.got.delete();
    i_tx_valid = 1'b1;
    repeat (n) begin
      i_tx_data = 8'($random(seed));
      @(posedge i_clk);
      if (o_tx_ready === 1'b1) sent.push_back(i_tx_data);
      @(negedge i_clk);
    end
    i_tx_valid = 1'b0;
    if (st) ck(fill_ok(sent.size()) && o_tx_ready === 1'b0, "fill");
    stall = 1'b0;
    for (t = 0; t < 5000 && printer_model_inst.got.size() < sent.size(); t++) @(posedge i_clk);
    foreach (sent[i]) ck(printer_model_inst.got[i] === sent[i], "fwd byte");
    // the last epp write may still wait for the settled wait release
    repeat (40) @(posedge i_clk);
    repeat (20) @(posedge i_clk) ck(o_strobe_n === 1'b1 && o_write_n === 1'b1, "not idle");
    ck(printer_model_inst.got.size() == sent.size(), "fwd count");
    if (m == MODE_EPP) ck(n_done == sent.size(), "epp done count");
  endtask : fwd
  task rev(input int n);
    int t;
    @(negedge i_clk);
    i_mode = MODE_ECP;
    i_reverse = 1'b1;
    dly = 4'($random(seed));
    sent.delete();
    repeat (n) begin
      sent.push_back(8'($random(seed)));
      printer_model_inst.snd.push_back(sent[$]);
    end
    for (t = 0; t < 5000 && sent.size() > 0; t++) begin
      i_rx_ready = 1'($random(seed));
      i_rx_stop = ($random(seed) & 3) == 0;
      @(posedge i_clk);
      if (o_rx_valid === 1'b1 && i_rx_ready) ck(o_rx_data === sent.pop_front(), "rx byte");
      @(negedge i_clk);
    end
    ck(sent.size() == 0, "rx stuck");
    i_reverse = 1'b0;
    i_rx_stop = 1'b0;
  endtask : rev
  initial begin
    seed = 74;
    {i_reverse, i_epp_write, i_tx_valid, i_rx_ready, i_rx_stop, stall, req} = 7'h00;
    i_tx_data = 8'h00;
    dly = 4'h0;
    i_mode = MODE_FIFO;
    i_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    fwd(MODE_FIFO, 6, 1'b0);
    fwd(MODE_ECP, 6, 1'b0);
    fwd(MODE_ECP, 20, 1'b1);
    @(negedge i_clk) req = 1'b1;
    repeat (20) @(negedge i_clk);
    ck(o_reverse_req === 1'b1, "no reverse request");
    req = 1'b0;
    rev(5);
    @(negedge i_clk) i_epp_write = 1'b1;
    fwd(MODE_EPP, 3, 1'b0);
    complete_run();
  end
endmodule : ecp_epp_parallel_handshake_tb
